// file: hw/hub_cfg_pkg.sv
// Constants shared by the hub string and port configuration register bank
package hub_cfg_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int ADDR_WIDTH = 10;
    localparam int DATA_WIDTH = 32;
    localparam int INDEX_WIDTH = 8;
    localparam int INDEX_LSB = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] PRODUCT_LENGTH_INDEX = 8'h14;
    localparam logic [7:0] SERIAL_LENGTH_INDEX = 8'h15;
    localparam logic [7:0] PRODUCT_TEXT_FIRST = 8'h54;
    localparam logic [7:0] PRODUCT_TEXT_LAST = 8'h91;
    localparam logic [7:0] SERIAL_TEXT_FIRST = 8'h92;
    localparam logic [7:0] SERIAL_TEXT_LAST = 8'hCF;
    localparam logic [7:0] CHARGING_ENABLE_INDEX = 8'hD0;
    localparam logic [7:0] UPSTREAM_BOOST_INDEX = 8'hF6;

    // ****************************************************************
    // Text storage
    // ****************************************************************
    localparam int CHAR_WIDTH = 16;
    localparam int CHAR_ADDR_WIDTH = 6;
    localparam int CHAR_DEPTH = 64;
    localparam logic [4:0] MAX_CHARS = 5'h1F;
    localparam logic [5:0] AREA_CHARS = 6'h1F;

    // ****************************************************************
    // Field layouts and reset values
    // ****************************************************************
    localparam int CHARGE_PORT_LSB = 1;
    localparam int CHARGE_PORT_MSB = 4;
    localparam int PORT_COUNT = 4;
    localparam int BOOST_MSB = 1;
    localparam logic [3:0] CHARGE_RESET = 4'h0;
    localparam logic [1:0] BOOST_RESET = 2'h0;
    localparam logic [4:0] LENGTH_RESET = 5'h00;

    // Drive strength codes
    localparam logic [1:0] BOOST_NORMAL = 2'h0;
    localparam logic [1:0] BOOST_LOW = 2'h1;
    localparam logic [1:0] BOOST_MEDIUM = 2'h2;
    localparam logic [1:0] BOOST_HIGH = 2'h3;

    typedef enum logic [1:0] {
        port_idle,
        port_axi_text,
        port_axi_resp,
        port_desc_text
    } port_state_type;

endpackage

// file: hw/text_store.sv
// Character-wide text memory with byte write enables and registered read data
`timescale 1ns/1ps

module text_store
    import hub_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic write_low,
    input wire logic write_high,
    input wire logic [hub_cfg_pkg::CHAR_ADDR_WIDTH-1:0] write_addr,
    input wire logic [7:0] write_byte,
    input wire logic [hub_cfg_pkg::CHAR_ADDR_WIDTH-1:0] read_addr,
    output logic [hub_cfg_pkg::CHAR_WIDTH-1:0] read_char
);
    logic [CHAR_WIDTH-1:0] cells [0:CHAR_DEPTH-1];

    // Low byte sits at the even byte address, high byte right after it
    always_ff @(posedge ref_clk) begin
        if (write_low) begin
            cells[write_addr][7:0] <= write_byte;
        end
        if (write_high) begin
            cells[write_addr][15:8] <= write_byte;
        end
        read_char <= cells[read_addr];
    end

endmodule // text_store

// file: hw/hub_string_and_port_config.sv
// AXI4-Lite register bank for hub string storage and port drive settings
//
// How it works
// (RL1) Product text at indices 54h-91h, UTF-16LE.
// (RL2) Serial text at indices 92h-CFh, UTF-16LE.
// (RL3) At most 31 characters, 62 bytes each.
// (RL4) Character low byte first, high byte next.
// (RL5) Characters packed in consecutive byte pairs.
// (RL6) Charging bits 1-4 enable downstream ports 1-4.
// (RL7) Charging bits 7,6,5,0 reserved, control nothing.
// (RL8) Boost field bits 1:0, bits 7:2 reserved.
// (RL9) Boost codes: normal, ~4%, ~8%, ~12%.
// (RL10) Software should keep boost at 00.
// (RL11) Product length at 14h, capped at 31.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module hub_string_and_port_config
    import hub_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AXI4-Lite slave
    input wire logic [hub_cfg_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [hub_cfg_pkg::DATA_WIDTH-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hub_cfg_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [hub_cfg_pkg::DATA_WIDTH-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // String descriptor character fetch
    input wire logic desc_req_valid,
    output logic desc_req_ready,
    input wire logic desc_req_serial,
    input wire logic [4:0] desc_req_index,
    output logic desc_valid,
    output logic [hub_cfg_pkg::CHAR_WIDTH-1:0] desc_char,
    output logic desc_in_range,
    output logic [4:0] desc_length,
    // Port configuration outputs
    output logic [hub_cfg_pkg::PORT_COUNT-1:0] port_charge_enable,
    output logic [1:0] drive_boost_level
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    function automatic logic is_text(input logic [INDEX_WIDTH-1:0] idx);
        is_text = (idx >= PRODUCT_TEXT_FIRST) && (idx <= SERIAL_TEXT_LAST);
    endfunction

    // Both areas are one packed byte run, so one offset covers them
    function automatic logic [6:0] text_offset(input logic [INDEX_WIDTH-1:0] idx);
        logic [INDEX_WIDTH-1:0] diff;
        diff = idx - PRODUCT_TEXT_FIRST;
        text_offset = diff[6:0];
    endfunction

    function automatic logic is_mapped(input logic [INDEX_WIDTH-1:0] idx);
        is_mapped = is_text(idx) || (idx == PRODUCT_LENGTH_INDEX) || (idx == SERIAL_LENGTH_INDEX)
            || (idx == CHARGING_ENABLE_INDEX) || (idx == UPSTREAM_BOOST_INDEX);
    endfunction

    // Counts above the area size are cut to the largest legal length
    function automatic logic [4:0] clamp_length(input logic [7:0] value);
        clamp_length = (value > {3'h0, MAX_CHARS}) ? MAX_CHARS : value[4:0];
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    port_state_type state;
    port_state_type next_state;

    logic aw_held;
    logic w_held;
    logic [INDEX_WIDTH-1:0] aw_index;
    logic [7:0] w_byte;
    logic w_lane;

    logic [4:0] product_text_length;
    logic [4:0] serial_text_length;
    logic [CHARGE_PORT_MSB:CHARGE_PORT_LSB] charging_port_enable;
    logic [BOOST_MSB:0] upstream_drive_boost;

    logic rd_byte_high;
    logic desc_range_held;
    logic [CHAR_WIDTH-1:0] mem_char;

    // ****************************************************************
    // Write channel decode
    // ****************************************************************

    wire [INDEX_WIDTH-1:0] next_aw_index = s_axi_awaddr[INDEX_LSB +: INDEX_WIDTH];
    wire take_aw = s_axi_awvalid && s_axi_awready;
    wire take_w = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire write_hit = is_mapped(aw_index);
    wire write_en = do_write && w_lane && write_hit;
    wire [6:0] wr_offset = text_offset(aw_index);
    wire wr_text = write_en && is_text(aw_index);
    wire wr_low = wr_text && !wr_offset[0]; // see (RL4)
    wire wr_high = wr_text && wr_offset[0]; // see (RL4)
    wire [CHAR_ADDR_WIDTH-1:0] wr_char_addr = wr_offset[6:1]; // see (RL5)

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    // ****************************************************************
    // Read channel and descriptor arbitration
    // ****************************************************************

    wire [INDEX_WIDTH-1:0] ar_index = s_axi_araddr[INDEX_LSB +: INDEX_WIDTH];
    wire [6:0] rd_offset = text_offset(ar_index);
    wire take_ar = s_axi_arvalid && s_axi_arready;
    wire ar_text = take_ar && is_text(ar_index);
    wire take_desc = desc_req_valid && desc_req_ready;

    assign s_axi_arready = (state == port_idle);
    // Bus reads win the shared read port; the fetch waits until the read data is taken and port_idle returns
    assign desc_req_ready = (state == port_idle) && !s_axi_arvalid;

    // Serial characters start 31 character slots after product ones
    wire [5:0] desc_char_addr = desc_req_serial ? (6'(desc_req_index) + AREA_CHARS) : 6'(desc_req_index);
    wire [4:0] desc_len_sel = desc_req_serial ? serial_text_length : product_text_length;
    wire desc_hit = desc_req_index < desc_len_sel; // see (RL3) (RL11)

    wire [CHAR_ADDR_WIDTH-1:0] rd_char_addr = (state == port_idle && s_axi_arvalid) ? rd_offset[6:1] : desc_char_addr;

    wire [7:0] reg_byte =
        (ar_index == PRODUCT_LENGTH_INDEX) ? {3'h0, product_text_length} :
        (ar_index == SERIAL_LENGTH_INDEX) ? {3'h0, serial_text_length} :
        (ar_index == CHARGING_ENABLE_INDEX) ? {3'h0, charging_port_enable, 1'b0} : // see (RL7)
        (ar_index == UPSTREAM_BOOST_INDEX) ? {6'h00, upstream_drive_boost} : // see (RL8)
        8'h00;

    wire [7:0] mem_byte = rd_byte_high ? mem_char[15:8] : mem_char[7:0]; // see (RL4)

    text_store store (
        .ref_clk(ref_clk),
        .write_low(wr_low),
        .write_high(wr_high),
        .write_addr(wr_char_addr),
        .write_byte(w_byte),
        .read_addr(rd_char_addr),
        .read_char(mem_char)
    );

    // ****************************************************************
    // Read sequencer
    // ****************************************************************

    always_comb begin
        next_state = state;
        unique case (state)
            port_idle: begin
                if (ar_text) begin
                    next_state = port_axi_text;
                end else if (take_ar) begin
                    next_state = port_axi_resp;
                end else if (take_desc) begin
                    next_state = port_desc_text;
                end
            end
            port_axi_text: begin
                next_state = port_axi_resp;
            end
            port_axi_resp: begin
                if (s_axi_rready) begin
                    next_state = port_idle;
                end
            end
            port_desc_text: begin
                next_state = port_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= port_idle;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            rd_byte_high <= 1'b0;
        end else if (take_ar) begin
            s_axi_rvalid <= !is_text(ar_index);
            s_axi_rdata <= {24'h00_0000, reg_byte};
            s_axi_rresp <= is_mapped(ar_index) ? RESP_OKAY : RESP_DECERR;
            rd_byte_high <= rd_offset[0];
        end else if (state == port_axi_text) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, mem_byte};
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Descriptor answer
    // ****************************************************************

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            desc_valid <= 1'b0;
            desc_char <= 16'h0000;
            desc_in_range <= 1'b0;
            desc_length <= 5'h00;
            desc_range_held <= 1'b0;
        end else begin
            desc_valid <= (state == port_desc_text);
            if (take_desc) begin
                desc_range_held <= desc_hit;
                desc_length <= desc_len_sel;
            end
            if (state == port_desc_text) begin
                // Characters past the programmed length read as zero
                desc_char <= desc_range_held ? mem_char : 16'h0000; // see (RL1) (RL2) (RL11)
                desc_in_range <= desc_range_held;
            end
        end
    end

    // ****************************************************************
    // Write channel
    // ****************************************************************

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            aw_index <= 8'h00;
        end else if (take_aw) begin
            aw_held <= 1'b1;
            aw_index <= next_aw_index;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (take_w) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            product_text_length <= LENGTH_RESET;
            serial_text_length <= LENGTH_RESET;
        end else if (write_en) begin
            if (aw_index == PRODUCT_LENGTH_INDEX) begin
                product_text_length <= clamp_length(w_byte); // see (RL11) (RL3)
            end
            if (aw_index == SERIAL_LENGTH_INDEX) begin
                serial_text_length <= clamp_length(w_byte); // see (RL3)
            end
        end
    end

    // Reset leaves boost at normal drive so a fresh hub stays compliant
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            charging_port_enable <= CHARGE_RESET;
            upstream_drive_boost <= BOOST_RESET; // see (RL10)
        end else if (write_en) begin
            if (aw_index == CHARGING_ENABLE_INDEX) begin
                charging_port_enable <= w_byte[CHARGE_PORT_MSB:CHARGE_PORT_LSB]; // see (RL6) (RL7)
            end
            if (aw_index == UPSTREAM_BOOST_INDEX) begin
                upstream_drive_boost <= w_byte[BOOST_MSB:0]; // see (RL8)
            end
        end
    end

    // ****************************************************************
    // Port outputs
    // ****************************************************************

    assign port_charge_enable = charging_port_enable; // see (RL6)
    // Codes pass straight through: 0 normal, 1 low, 2 medium, 3 high
    assign drive_boost_level = upstream_drive_boost; // see (RL9)

endmodule // hub_string_and_port_config

// file: test/hub_cfg_props.sv
// Concurrent checks and covers for the hub string and port configuration bank
`timescale 1ns/1ps

module hub_cfg_props
    import hub_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [hub_cfg_pkg::DATA_WIDTH-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic desc_req_valid,
    input wire logic desc_req_ready,
    input wire logic [4:0] desc_req_index,
    input wire logic desc_valid,
    input wire logic [hub_cfg_pkg::CHAR_WIDTH-1:0] desc_char,
    input wire logic desc_in_range,
    input wire logic [4:0] desc_length,
    input wire logic [hub_cfg_pkg::PORT_COUNT-1:0] port_charge_enable,
    input wire logic [1:0] drive_boost_level
);
    import hub_cfg_pkg::*;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_desc_answer: assert property (desc_req_valid && desc_req_ready |=> !desc_valid ##1 desc_valid)
        else $error("descriptor answer not two cycles after take");
    a_desc_pulse: assert property (desc_valid |=> !desc_valid)
        else $error("descriptor valid longer than one cycle");
    a_desc_range: assert property (desc_valid
        |-> desc_in_range == ($past(desc_req_index, 2) < desc_length))
        else $error("in-range flag disagrees with length");
    a_range_zero: assert property (desc_valid && !desc_in_range |-> desc_char == 16'h0000)
        else $error("character past the length not zero");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data wider than one byte");
    a_charge_cause: assert property ($changed(port_charge_enable)
        |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("charging enables changed without a write");
    a_boost_cause: assert property ($changed(drive_boost_level)
        |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("boost level changed without a write");

    c_out_of_range: cover property (desc_valid && !desc_in_range);
    c_fetch_waits: cover property (desc_req_valid && !desc_req_ready);
    c_decode_error: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
    c_boost_high: cover property (drive_boost_level == BOOST_HIGH);
endmodule // hub_cfg_props

bind hub_string_and_port_config hub_cfg_props i_props (.*);

// file: test/desc_host_model.sv
// Upstream host model that fetches string descriptor characters
`timescale 1ns/1ps

module desc_host_model (
    input wire logic ref_clk,
    input wire logic desc_req_ready,
    input wire logic desc_valid,
    input wire logic [15:0] desc_char,
    input wire logic desc_in_range,
    input wire logic [4:0] desc_length,
    output logic desc_req_valid,
    output logic desc_req_serial,
    output logic [4:0] desc_req_index
);
    initial begin
        desc_req_valid = 1'h0;
        desc_req_serial = 1'h0;
        desc_req_index = 5'h00;
    end

    // Index is five bits, 0 to 31; released lines show inverted values so stale data cannot pass
    task automatic fetch(input logic serial, input logic [4:0] index, input int gap,
            output logic [15:0] char_seen, output logic range_seen, output logic [4:0] length_seen);
        repeat (gap) @(posedge ref_clk);
        desc_req_valid <= 1'h1;
        desc_req_serial <= serial;
        desc_req_index <= index;
        do @(posedge ref_clk); while (desc_req_ready !== 1'h1);
        desc_req_valid <= 1'h0;
        desc_req_serial <= ~serial;
        desc_req_index <= ~index;
        do @(posedge ref_clk); while (desc_valid !== 1'h1);
        char_seen = desc_char;
        range_seen = desc_in_range;
        length_seen = desc_length;
    endtask
endmodule // desc_host_model

// file: test/tb_top.sv
// Self-checking bench for the hub string and port configuration bank
`timescale 1ns/1ps

module tb_top;
    import hub_cfg_pkg::*;

    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [ADDR_WIDTH-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_WIDTH-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic desc_req_valid, desc_req_ready, desc_req_serial, desc_valid, desc_in_range, rng;
    logic [4:0] desc_req_index, desc_length, len;
    logic [CHAR_WIDTH-1:0] desc_char, ch, got;
    logic [PORT_COUNT-1:0] port_charge_enable;
    logic [1:0] drive_boost_level;
    int bad_count = 0;
    int compares = 0;

    always #2 ref_clk = ~ref_clk;

    hub_string_and_port_config i_dut (.*);
    desc_host_model i_host (.*);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] pch(input int n);
        return {8'h50 + 8'(n), 8'h20 + 8'(n)};
    endfunction

    function automatic logic [15:0] sch(input int n);
        return {8'hC0 + 8'(n), 8'h80 + 8'(n)};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Address and data go out together and each is dropped once taken
    task automatic wr(input logic [9:0] addr, input logic [7:0] data, input logic [3:0] strb = 4'hF);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {24'h000000, data};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic rchk(input logic [9:0] addr, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic fchk(input logic s, input int idx, input int gap, input logic [15:0] ec, input logic er, input int el);
        i_host.fetch(s, 5'(idx), gap, got, rng, len);
        chk(32'(got), 32'(ec));
        chk(32'(rng), 32'(er));
        chk(32'(len), 32'(el));
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        chk(32'(port_charge_enable), 32'h0);
        chk(32'(drive_boost_level), 32'(BOOST_RESET));
        rchk(10'h340, 32'h0, RESP_OKAY);
        rchk(10'h3D8, 32'h0, RESP_OKAY);
        rchk(10'h050, 32'h0, RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            wr(10'h340, 8'hE1 | (8'h02 << p));
            chk(32'(port_charge_enable), 32'h1 << p);
            rchk(10'h340, 32'h2 << p, RESP_OKAY);
        end
        wr(10'h340, 8'h00, 4'hE);
        chk(32'(port_charge_enable), 32'h8);
        for (int c = 0; c < 4; c++) begin
            wr(10'h3D8, 8'hFC | 8'(c));
            chk(32'(drive_boost_level), 32'(c));
            rchk(10'h3D8, 32'(c), RESP_OKAY);
        end
        wr(10'h3D8, {6'h00, BOOST_NORMAL});
        // Fill both areas two bytes per character, low byte first
        for (int n = 0; n < 31; n++) begin
            ch = pch(n);
            wr(10'h150 + 10'(8 * n), ch[7:0]);
            wr(10'h154 + 10'(8 * n), ch[15:8]);
            ch = sch(n);
            wr(10'h248 + 10'(8 * n), ch[7:0]);
            wr(10'h24C + 10'(8 * n), ch[15:8]);
        end
        rchk(10'h150, 32'h20, RESP_OKAY);
        rchk(10'h154, 32'h50, RESP_OKAY);
        rchk(10'h244, 32'h6E, RESP_OKAY);
        rchk(10'h33C, 32'hDE, RESP_OKAY);
        rchk(10'h14C, 32'h0, RESP_DECERR);
        rchk(10'h344, 32'h0, RESP_DECERR);
        wr(10'h3DC, 8'hFF);
        chk(32'(resp), 32'(RESP_DECERR));
        rchk(10'h3DC, 32'h0, RESP_DECERR);
        wr(10'h050, 8'h28);
        rchk(10'h050, 32'h1F, RESP_OKAY);
        wr(10'h054, 8'h1F);
        rchk(10'h054, 32'h1F, RESP_OKAY);
        fchk(1'h0, 30, 0, pch(30), 1'h1, 31);
        fchk(1'h1, 30, 2, sch(30), 1'h1, 31);
        fchk(1'h1, 0, 0, sch(0), 1'h1, 31);
        fchk(1'h1, 31, 0, 16'h0000, 1'h0, 31);
        wr(10'h050, 8'h05);
        for (int i = 0; i < 7; i++) begin
            fchk(1'h0, i, i % 2, (i < 5) ? pch(i) : 16'h0000, i < 5, 5);
        end
        // A bus read and a fetch raised together: the fetch must wait its turn
        fork
            rchk(10'h158, 32'h21, RESP_OKAY);
            fchk(1'h0, 1, 0, pch(1), 1'h1, 5);
        join
        final_report();
    end

    initial begin
        #40000;
        bad_count++;
        final_report();
    end
endmodule // tb_top
